// [core/awd_pkg.sv]
// shared constants of the acceleration window event detector
// assumes: registers are one aligned 32-bit word each, at 4 x index
package awd_pkg;

  // sample and limit width, two's complement
  localparam int SAMPLE_W = 12;
  localparam int AXES = 3;

  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CFG_ONE = 8'h2F;
  localparam logic [7:0] IDX_CFG_TWO = 8'h30;
  localparam logic [7:0] IDX_OUT_DB = 8'h31;
  localparam logic [7:0] IDX_IN_DB = 8'h32;
  localparam logic [7:0] IDX_LOW_LO = 8'h33;
  localparam logic [7:0] IDX_LOW_HI = 8'h34;
  localparam logic [7:0] IDX_UP_LO = 8'h35;
  localparam logic [7:0] IDX_UP_HI = 8'h36;
  localparam logic [7:0] IDX_CTRL = 8'h38;
  localparam logic [7:0] IDX_STATUS = 8'h39;

  // detector_config_two fields
  localparam int C2_ENABLE = 7;
  localparam int C2_REF_FLAG = 6;
  localparam int C2_POLICY = 5;
  localparam int C2_OUT_DEC = 4;
  localparam int C2_IN_DEC = 3;
  localparam int C2_IN_AND = 2;
  localparam int C2_RELATIVE = 1;
  localparam int C2_REF_REQ = 0;

  // detector_config_one fields; axis enables X at the top bit
  localparam int C1_OUT_LATCH = 7;
  localparam int C1_IN_LATCH = 6;
  localparam int C1_OUT_EN_LSB = 3;
  localparam int C1_IN_EN_LSB = 0;

  // control register fields
  localparam int CT_ACTIVE = 0;
  localparam int CT_SLEEP = 1;
  localparam int CT_POWER_LSB = 2;
  localparam int CT_VECTOR = 4;
  localparam int CT_RANGE_LSB = 5;

  // status register fields
  localparam int ST_OUT_FLAG = 0;
  localparam int ST_IN_FLAG = 1;
  localparam int ST_OUT_COND = 2;
  localparam int ST_IN_COND = 3;
  localparam int ST_STRAP = 4;

  // reset values for the two boot strap states
  localparam logic [7:0] RST_CFG_TWO_STRAP0 = 8'h00;
  localparam logic [7:0] RST_CFG_TWO_STRAP1 = 8'hD8;
  localparam logic [7:0] RST_CFG_ONE_STRAP0 = 8'h00;
  localparam logic [7:0] RST_CFG_ONE_STRAP1 = 8'h38;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // ahb transfer type with bit 1 set marks a real transfer
  localparam int HTRANS_REAL = 1;

endpackage : awd_pkg

// [core/awd_debounce.sv]
// one debounce counter for a window condition
// assumes: step is a one-cycle pulse per counter period, clear overrides
`timescale 1ns/1ns
module awd_debounce
  import awd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic step,
  input wire logic cond,
  input wire logic [7:0] limit,
  input wire logic dec_mode,
  output logic active,
  output logic [7:0] count
);

  // next count; saturates at the programmed count
  logic [7:0] next_count;

  //////////////////////////////////////////////////////////////////////
  // count up while true, clear or count down while false
  always_comb begin
    next_count = count;
    if (cond) begin
      if (count < limit) begin
        next_count = count + 8'h01; // RULE_22
      end
    end else if (dec_mode && count != 8'h00) begin
      next_count = count - 8'h01; // RULE_12
    end else begin
      next_count = 8'h00; // RULE_11
    end
  end

  //////////////////////////////////////////////////////////////////////
  // counter and recognised condition
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
      active <= 1'b0;
    end else if (clear) begin
      count <= 8'h00; // RULE_09
      active <= 1'b0;
    end else if (step) begin
      count <= next_count;
      if (cond) begin
        // zero count recognises at once; else when the count is reached
        active <= active | (next_count >= limit); // RULE_08 RULE_10
      end else if (dec_mode) begin
        // stays asserted until the count is back at zero
        active <= active & (next_count != 8'h00); // RULE_13
      end else begin
        active <= 1'b0; // RULE_11
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_zero_follows;
    @(posedge clk) disable iff (!rst_n)
      (step && !clear && limit == 8'h00 && !dec_mode) |=> (active == $past(cond));
  endproperty
  a_zero_follows: assert property (p_zero_follows) // RULE_10
    else $error("zero count event does not follow condition");

  property p_hold_count;
    @(posedge clk) disable iff (!rst_n)
      (step && !clear && cond && limit != 8'h00 && count + 8'h01 < limit
       && !active) |=> !active;
  endproperty
  a_hold_count: assert property (p_hold_count) // RULE_08
    else $error("event before debounce count reached");

  property p_dec_keep;
    @(posedge clk) disable iff (!rst_n)
      (step && !clear && !cond && dec_mode && active && count > 8'h01)
      |=> active && count == $past(count) - 8'h01;
  endproperty
  a_dec_keep: assert property (p_dec_keep) // RULE_12
    else $error("decrement mode dropped event early");

  property p_clear_resets;
    @(posedge clk) disable iff (!rst_n)
      clear |=> (count == 8'h00 && !active);
  endproperty
  a_clear_resets: assert property (p_clear_resets) // RULE_09
    else $error("counter not reset on mode change");

endmodule : awd_debounce

// [core/awd_detector.sv]
// acceleration window event detector with an ahb-lite register slave
// assumes: samples stand valid when SAMPLE_TICK pulses once per counter
// period; the one slave's HREADYOUT is the bus HREADY
//
// How it works
// RULE_01: limits are 12-bit, split low/high byte
// RULE_02: limit counts weigh like sample counts
// RULE_03: outside window event after debounce
// RULE_04: inside window event after own debounce
// RULE_05: software keeps upper above lower limit
// RULE_06: separate outside and inside debounce counts
// RULE_07: counters step once per sample period
// RULE_08: condition true after held debounce count
// RULE_09: power mode changes reset both counters; code resets them only on standby/active changes and on entering sleep
// RULE_10: zero count follows condition directly
// RULE_11: mode bit picks clear or decrement
// RULE_12: decrement mode counts down, event held
// RULE_13: decrement mode drops event at zero
// RULE_14: strap picks config two reset value
// RULE_15: strapped high, software stays low power
// RULE_16: vector magnitude may replace x input
// RULE_17: axis selects independent per event type
// RULE_18: inside axes combine by and or or
// RULE_19: absolute or relative comparison selectable
// RULE_20: latched flags rise on edge, read clears
// RULE_21: relative mode subtracts stored reference
// RULE_22: counter counts up, saturates at count
`timescale 1ns/1ns
module awd_detector
  import awd_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire logic BOOT_STRAP_SELECT,
  input wire logic SAMPLE_TICK,
  input wire logic [11:0] X_SAMPLE,
  input wire logic [11:0] Y_SAMPLE,
  input wire logic [11:0] Z_SAMPLE,
  input wire logic [11:0] VECTOR_SAMPLE,
  output logic OUTSIDE_WINDOW_EVENT,
  output logic INSIDE_WINDOW_EVENT
);

  //////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] detector_config_one; // axis enables and latching
  logic [7:0] detector_config_two; // enable, modes, reference
  logic [7:0] outside_debounce_count;
  logic [7:0] inside_debounce_count;
  logic [11:0] lower_limit; // both bytes of the lower limit
  logic [11:0] upper_limit; // both bytes of the upper limit
  logic [7:0] control; // operation and power mode
  logic strap; // strap caught after reset release
  logic strap_done; // strap already applied

  // bus phase state
  logic dp_write; // write data phase pending
  logic rd_wait; // first cycle of a read data phase
  logic [7:0] dp_idx; // register index of the data phase
  logic take; // transfer accepted in this address phase
  logic wr_go; // write data stands this cycle
  logic status_rd; // status read clears latched flags

  // detector state
  logic [11:0] ref_sample [AXES]; // stored per-axis reference
  logic [AXES-1:0] out_c; // per-axis outside condition
  logic [AXES-1:0] in_c; // per-axis inside condition
  logic [AXES-1:0] out_en;
  logic [AXES-1:0] in_en;
  logic [11:0] axis_in [AXES]; // comparator inputs, X at top
  logic outside_cond;
  logic inside_cond;
  logic out_active; // debounced outside condition
  logic in_active; // debounced inside condition
  logic out_prev; // for edge detection under latching
  logic in_prev;
  logic out_flag;
  logic in_flag;
  logic prev_active;
  logic prev_sleep;
  logic mode_change; // counter reset on power transitions
  logic det_on; // detector enabled and running
  logic step; // counter period pulse
  logic ref_req; // reference capture requested

  //////////////////////////////////////////////////////////////////////
  // ahb-lite slave: reads take one wait state so the data is registered
  assign take = HSEL && HREADY && HTRANS[HTRANS_REAL];
  assign HREADYOUT = !rd_wait;
  assign HRESP = 1'b0; // always okay, unmapped included
  assign wr_go = dp_write;
  assign status_rd = rd_wait && dp_idx == IDX_STATUS;

  // address phase capture
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dp_write <= 1'b0;
      rd_wait <= 1'b0;
      dp_idx <= 8'h00;
    end else begin
      dp_write <= take && HWRITE;
      rd_wait <= take && !HWRITE;
      if (take) begin
        dp_idx <= HADDR[9:2];
      end
    end
  end

  // read data registered at the end of the wait state
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (rd_wait) begin
      unique case (dp_idx)
        IDX_CFG_ONE: HRDATA <= {24'h000000, detector_config_one};
        IDX_CFG_TWO: HRDATA <= {24'h000000, detector_config_two};
        IDX_OUT_DB: HRDATA <= {24'h000000, outside_debounce_count};
        IDX_IN_DB: HRDATA <= {24'h000000, inside_debounce_count};
        IDX_LOW_LO: HRDATA <= {24'h000000, lower_limit[7:0]}; // RULE_01
        IDX_LOW_HI: HRDATA <= {28'h0000000, lower_limit[11:8]};
        IDX_UP_LO: HRDATA <= {24'h000000, upper_limit[7:0]};
        IDX_UP_HI: HRDATA <= {28'h0000000, upper_limit[11:8]};
        IDX_CTRL: HRDATA <= {24'h000000, control};
        IDX_STATUS: HRDATA <= {27'h0000000, strap, in_active,
                               out_active, in_flag, out_flag};
        default: HRDATA <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // strap capture and configuration registers; strap values load on
  // the first clock after release, never under the reset itself
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap <= 1'b0;
      strap_done <= 1'b0;
      detector_config_one <= RST_CFG_ONE_STRAP0;
      detector_config_two <= RST_CFG_TWO_STRAP0;
    end else if (!strap_done) begin
      strap <= BOOT_STRAP_SELECT;
      strap_done <= 1'b1;
      // RULE_14
      detector_config_two <= BOOT_STRAP_SELECT ? RST_CFG_TWO_STRAP1
                                               : RST_CFG_TWO_STRAP0;
      detector_config_one <= BOOT_STRAP_SELECT ? RST_CFG_ONE_STRAP1
                                               : RST_CFG_ONE_STRAP0;
    end else begin
      if (wr_go && dp_idx == IDX_CFG_ONE) begin
        detector_config_one <= HWDATA[7:0]; // RULE_17
      end
      if (wr_go && dp_idx == IDX_CFG_TWO) begin
        detector_config_two <= HWDATA[7:0]; // RULE_11 RULE_19
        detector_config_two[C2_REF_REQ] <= 1'b0; // request is a pulse
      end
      // capture sets the flag and wins over a write in the same cycle
      if (ref_req) begin
        detector_config_two[C2_REF_FLAG] <= 1'b1;
      end
    end
  end

  assign ref_req = wr_go && dp_idx == IDX_CFG_TWO && HWDATA[C2_REF_REQ]
                   && strap_done;

  // limits and counts change only in standby, so a live run never sees
  // a half-written limit
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      outside_debounce_count <= RST_ZERO;
      inside_debounce_count <= RST_ZERO;
      lower_limit <= 12'h000;
      upper_limit <= 12'h000;
    end else if (wr_go && !control[CT_ACTIVE]) begin
      unique case (dp_idx)
        IDX_OUT_DB: outside_debounce_count <= HWDATA[7:0]; // RULE_06
        IDX_IN_DB: inside_debounce_count <= HWDATA[7:0]; // RULE_06
        IDX_LOW_LO: lower_limit[7:0] <= HWDATA[7:0]; // RULE_01
        IDX_LOW_HI: lower_limit[11:8] <= HWDATA[3:0]; // RULE_01
        IDX_UP_LO: upper_limit[7:0] <= HWDATA[7:0]; // RULE_01
        IDX_UP_HI: upper_limit[11:8] <= HWDATA[3:0]; // RULE_01
        default: ;
      endcase
    end
  end

  // control: active, sleep, power mode, vector select, range
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      control <= RST_ZERO;
    end else if (wr_go && dp_idx == IDX_CTRL) begin
      control <= HWDATA[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // power transitions: standby/active either way, or entering sleep
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prev_active <= 1'b0;
      prev_sleep <= 1'b0;
    end else begin
      prev_active <= control[CT_ACTIVE];
      prev_sleep <= control[CT_SLEEP];
    end
  end

  assign mode_change = (control[CT_ACTIVE] != prev_active)
                       || (control[CT_SLEEP] && !prev_sleep); // RULE_09
  assign det_on = detector_config_two[C2_ENABLE] && control[CT_ACTIVE];
  // tick: one output sample period, or measurement plus idle (flexible)
  assign step = det_on && SAMPLE_TICK; // RULE_07

  //////////////////////////////////////////////////////////////////////
  // comparator per axis; the limit count has the sample's own weight,
  // so the range setting needs no scaling here
  assign axis_in[2] = control[CT_VECTOR] ? VECTOR_SAMPLE
                                         : X_SAMPLE; // RULE_16
  assign axis_in[1] = Y_SAMPLE;
  assign axis_in[0] = Z_SAMPLE;
  assign out_en = detector_config_one[C1_OUT_EN_LSB +: AXES];
  assign in_en = detector_config_one[C1_IN_EN_LSB +: AXES];

  genvar gi;
  generate
    for (gi = 0; gi < AXES; gi++) begin : g_axis
      logic signed [12:0] value; // widened so the difference cannot wrap
      // reference capture on request
      always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          ref_sample[gi] <= 12'h000;
        end else if (ref_req) begin
          ref_sample[gi] <= axis_in[gi]; // RULE_21
        end
      end
      always_comb begin
        if (detector_config_two[C2_RELATIVE]) begin
          value = $signed({axis_in[gi][11], axis_in[gi]})
                  - $signed({ref_sample[gi][11], ref_sample[gi]}); // RULE_21
        end else begin
          value = $signed({axis_in[gi][11], axis_in[gi]}); // RULE_19
        end
      end
      // upper above lower is the writer's job; nothing guards it
      assign out_c[gi] = value > $signed({upper_limit[11], upper_limit})
        || value < $signed({lower_limit[11], lower_limit}); // RULE_03 RULE_02
      assign in_c[gi] = !out_c[gi]; // RULE_04
    end
  endgenerate

  // outside: any enabled axis; inside: and/or over enabled axes
  assign outside_cond = |(out_c & out_en); // RULE_03 RULE_17
  assign inside_cond = detector_config_two[C2_IN_AND]
                       ? (&(in_c | ~in_en)) && (|in_en)
                       : |(in_c & in_en); // RULE_18 RULE_04

  //////////////////////////////////////////////////////////////////////
  // two independent debounce counters
  awd_debounce u_out_db (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .clear(mode_change || !detector_config_two[C2_ENABLE]),
    .step(step),
    .cond(outside_cond),
    .limit(outside_debounce_count),
    .dec_mode(detector_config_two[C2_OUT_DEC]),
    .active(out_active),
    .count()
  );

  awd_debounce u_in_db (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .clear(mode_change || !detector_config_two[C2_ENABLE]),
    .step(step),
    .cond(inside_cond),
    .limit(inside_debounce_count),
    .dec_mode(detector_config_two[C2_IN_DEC]),
    .active(in_active),
    .count()
  );

  //////////////////////////////////////////////////////////////////////
  // event flags: real time, or latched on a rising edge until the
  // status read; a new edge in the read cycle wins over the clear
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_prev <= 1'b0;
      in_prev <= 1'b0;
      out_flag <= 1'b0;
      in_flag <= 1'b0;
    end else begin
      out_prev <= out_active;
      in_prev <= in_active;
      if (!detector_config_one[C1_OUT_LATCH]) begin
        out_flag <= out_active;
      end else if (out_active && !out_prev) begin
        out_flag <= 1'b1; // RULE_20
      end else if (status_rd) begin
        out_flag <= 1'b0; // RULE_20
      end
      if (!detector_config_one[C1_IN_LATCH]) begin
        in_flag <= in_active;
      end else if (in_active && !in_prev) begin
        in_flag <= 1'b1; // RULE_20
      end else if (status_rd) begin
        in_flag <= 1'b0; // RULE_20
      end
    end
  end

  assign OUTSIDE_WINDOW_EVENT = out_flag;
  assign INSIDE_WINDOW_EVENT = in_flag;

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_bus_okay;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (take && !HWRITE) |=> !HREADYOUT ##1 HREADYOUT && !HRESP;
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("read answer not after one wait state");

  property p_strap_reset;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (!strap_done && BOOT_STRAP_SELECT) |=>
        detector_config_two == RST_CFG_TWO_STRAP1; // RULE_14
  endproperty
  a_strap_reset: assert property (p_strap_reset) // RULE_14
    else $error("strap reset value wrong");

  property p_latch_hold;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (out_flag && detector_config_one[C1_OUT_LATCH] && !status_rd
       && $stable(detector_config_one)) |=> out_flag;
  endproperty
  a_latch_hold: assert property (p_latch_hold) // RULE_20
    else $error("latched flag dropped without status read");

  property p_standby_write;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (wr_go && control[CT_ACTIVE] && dp_idx == IDX_UP_LO)
      |=> $stable(upper_limit); // RULE_01
  endproperty
  a_standby_write: assert property (p_standby_write) // RULE_01
    else $error("limit written while active");

  property p_mode_reset;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (mode_change && !control[CT_ACTIVE]) |=> !out_active && !in_active;
  endproperty
  a_mode_reset: assert property (p_mode_reset) // RULE_09
    else $error("counters survived a mode change");

endmodule : awd_detector

// [verification/awd_sample_src.sv]
// sample source standing in for the sensor front end
// assumes: the bench calls send once per counter period
`timescale 1ns/1ns
module awd_sample_src (
  input wire logic clk,
  output logic tick,
  output logic [11:0] x_smp,
  output logic [11:0] y_smp,
  output logic [11:0] z_smp,
  output logic [11:0] v_smp
);
  // quiet until the first period
  initial begin
    tick = 1'b0;
    x_smp = 12'h000;
    y_smp = 12'h000;
    z_smp = 12'h000;
    v_smp = 12'h000;
  end
  // one period: samples valid only with the tick pulse
  task automatic send(input logic [11:0] x, input logic [11:0] v);
    @(posedge clk);
    tick <= 1'b1;
    x_smp <= x;
    y_smp <= 12'h000;
    z_smp <= 12'h000;
    v_smp <= v;
    @(posedge clk);
    tick <= 1'b0;
    // stale values scrambled so nothing leans on them
    x_smp <= ~x;
    y_smp <= 12'hFFF;
    z_smp <= 12'hFFF;
    v_smp <= ~v;
  endtask : send
endmodule : awd_sample_src

// [verification/tb_awd_detector.sv]
// bench for the window event detector, host side over ahb-lite
// assumes: one slave, its HREADYOUT is the bus HREADY
`timescale 1ns/1ns
module tb_awd_detector;
  import awd_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic strap = 1'b0;
  logic tick;
  logic [11:0] xs, ys, zs, vs;
  logic out_ev, in_ev;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] rd;
  // 125 MHz system clock
  always #4 sys_clk = ~sys_clk;
  awd_sample_src u_src (.clk(sys_clk), .tick(tick), .x_smp(xs),
    .y_smp(ys), .z_smp(zs), .v_smp(vs));
  awd_detector u_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .HSEL(1'b1),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
    .HRESP(hresp), .HRDATA(hrdata), .BOOT_STRAP_SELECT(strap),
    .SAMPLE_TICK(tick), .X_SAMPLE(xs), .Y_SAMPLE(ys), .Z_SAMPLE(zs),
    .VECTOR_SAMPLE(vs), .OUTSIDE_WINDOW_EVENT(out_ev),
    .INSIDE_WINDOW_EVENT(in_ev));
  ////////////////////////////////////////////////////////////////////
  // verdict, the one place the run ends
  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  // hang guard, well above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  // hready is looked at mid-cycle, it is settled there until the edge
  task automatic wait_rdy;
    do @(negedge sys_clk); while (hreadyout !== 1'b1);
  endtask : wait_rdy
  // one single word transfer; read data taken mid-cycle, before the closing edge
  task automatic ahb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    @(posedge sys_clk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    wait_rdy();
    @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata[7:0];
    chk("hresp", 8'h00, {7'h00, hresp});
    @(posedge sys_clk);
  endtask : ahb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    ahb(1'b1, idx, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] idx, logic [7:0] e);
    ahb(1'b0, idx, 8'h00);
    chk(nm, e, rd);
    // bits above the byte read as zero
    chk("rdata_top", 8'h00, hrdata[31:24] | hrdata[23:16] | hrdata[15:8]);
  endtask : rdc
  // one sample period, then both event pins judged after their edge
  task automatic smp(input logic [11:0] x, input logic [11:0] v,
                     input logic eo, input logic ei);
    u_src.send(x, v);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("outside_event", {7'h00, eo}, {7'h00, out_ev});
    chk("inside_event", {7'h00, ei}, {7'h00, in_ev});
  endtask : smp
  task automatic do_reset(input logic s);
    rst_n <= 1'b0;
    strap <= s;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////
  // limits -100 / +100, debounce 2 outside, 0 inside, x axis only
  task automatic t_setup;
    wr(IDX_LOW_LO, 8'h9C);
    wr(IDX_LOW_HI, 8'hFF);
    rdc("lower_hi", IDX_LOW_HI, 8'h0F);
    wr(IDX_UP_LO, 8'h64);
    wr(IDX_UP_HI, 8'h00);
    wr(IDX_OUT_DB, 8'h02);
    wr(IDX_IN_DB, 8'h00);
    rdc("outside_db", IDX_OUT_DB, 8'h02);
    rdc("unmapped", 8'h3F, 8'h00);
    wr(IDX_CFG_ONE, 8'h24);
    wr(IDX_CFG_TWO, 8'h80);
    wr(IDX_CTRL, 8'h01);
    wr(IDX_UP_LO, 8'h11);
    rdc("upper_lo", IDX_UP_LO, 8'h64);
  endtask : t_setup
  // clear mode: two periods to raise, one false period drops it
  task automatic t_clear;
    smp(12'h0C8, 12'h000, 1'b0, 1'b0);
    smp(12'h0C8, 12'h000, 1'b1, 1'b0);
    smp(12'h065, 12'h000, 1'b1, 1'b0);
    smp(12'h064, 12'h000, 1'b0, 1'b1);
    smp(12'hF9B, 12'h000, 1'b0, 1'b0);
    smp(12'hF9C, 12'h000, 1'b0, 1'b1);
  endtask : t_clear
  // decrement mode keeps the event until the count drains
  task automatic t_decrement;
    wr(IDX_CFG_TWO, 8'h90);
    smp(12'h0C8, 12'h000, 1'b0, 1'b0);
    smp(12'h0C8, 12'h000, 1'b1, 1'b0);
    smp(12'h000, 12'h000, 1'b1, 1'b1);
    smp(12'h000, 12'h000, 1'b0, 1'b1);
  endtask : t_decrement
  // leaving and re-entering active throws away a partial count
  task automatic t_power;
    smp(12'h0C8, 12'h000, 1'b0, 1'b0);
    // entering sleep throws the partial count away as well
    wr(IDX_CTRL, 8'h03);
    smp(12'h0C8, 12'h000, 1'b0, 1'b0);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_CTRL, 8'h01);
    smp(12'h0C8, 12'h000, 1'b0, 1'b0);
    smp(12'h0C8, 12'h000, 1'b1, 1'b0);
    wr(IDX_CFG_TWO, 8'h80);
    smp(12'h000, 12'h000, 1'b0, 1'b1);
  endtask : t_power
  // magnitude on the x channel, raw x ignored
  task automatic t_vector;
    wr(IDX_CTRL, 8'h11);
    smp(12'h000, 12'h0C8, 1'b0, 1'b0);
    smp(12'h000, 12'h0C8, 1'b1, 1'b0);
    wr(IDX_CTRL, 8'h01);
  endtask : t_vector
  // latched outside flag holds until the status read
  task automatic t_latch;
    wr(IDX_CTRL, 8'h00);
    wr(IDX_OUT_DB, 8'h00);
    wr(IDX_CFG_ONE, 8'hA4);
    wr(IDX_CTRL, 8'h01);
    smp(12'h0C8, 12'h000, 1'b1, 1'b0);
    smp(12'h000, 12'h000, 1'b1, 1'b1);
    ahb(1'b0, IDX_STATUS, 8'h00);
    chk("status", 8'h0B, rd);
    @(negedge sys_clk);
    chk("latched_event", 8'h00, {7'h00, out_ev});
  endtask : t_latch
  // all three inside axes by or, then by and; y and z rest at zero;
  // then a reference taken while the source shows the inverted last x
  task automatic t_combine;
    wr(IDX_CFG_ONE, 8'h27);
    smp(12'h0C8, 12'h000, 1'b1, 1'b1);
    wr(IDX_CFG_TWO, 8'h84);
    smp(12'h0C8, 12'h000, 1'b1, 1'b0);
    wr(IDX_CFG_TWO, 8'h83);
    rdc("cfg_two_ref", IDX_CFG_TWO, 8'hC2);
    smp(12'h000, 12'h000, 1'b1, 1'b1);
    wr(IDX_CFG_TWO, 8'h80);
  endtask : t_combine
  // strapped reset values of both configuration registers
  task automatic t_strap;
    // reset is driven just after a rising edge, like every input
    @(posedge sys_clk);
    do_reset(1'b1);
    rdc("cfg_two_strap", IDX_CFG_TWO, 8'hD8);
    rdc("cfg_one_strap", IDX_CFG_ONE, 8'h38);
    rdc("status_strap", IDX_STATUS, 8'h10);
  endtask : t_strap
  ////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b0);
    rdc("cfg_two", IDX_CFG_TWO, 8'h00);
    t_setup();
    t_clear();
    t_decrement();
    t_power();
    t_vector();
    t_latch();
    t_combine();
    t_strap();
    finish_test();
  end
endmodule : tb_awd_detector
